// ===== src/rsq_map.vh
/*
 * Constants of the reset sequencer: addresses, bit positions, reset values and timing counts.
 * Assumes it is included by bare name into the sequencer module.
 */
`ifndef RSQ_MAP_VH
`define RSQ_MAP_VH

// ----------------------------------------
// Register addresses and fields
// ----------------------------------------
`define RSQ_PM0_ADDR 16'h0004
`define RSQ_PM0_SWRST_BIT 3
`define RSQ_USB_CTRL_ADDR 16'h000c
`define RSQ_USB_ATT_ADDR 16'h001f
`define RSQ_USB_LO_ADDR 16'h0300
`define RSQ_USB_HI_ADDR 16'h033c
`define RSQ_FS_LO_ADDR 16'h03db
`define RSQ_FS_HI_ADDR 16'h03df

// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define RSQ_PIN_LOW_MIN_CYC 20
`define RSQ_SW_PULSE_CYC 20
`define RSQ_DIV_RESET 3'h3

`endif

// ===== src/rsq_reset_sequencer.v
/*
 * Reset sequencer: combines the external reset pin and the software reset request into
 * a core reset, port float control, storage preserve qualifiers and the post-reset clock divider.
 * Assumes the CPU writes byte registers over a simple strobe port on core_clk_in and that the
 * reset pin comes asynchronously from an external circuit.
 */
`timescale 1ns/1ps
`include "rsq_map.vh"

module rsq_reset_sequencer #(
	parameter LOW_MIN = `RSQ_PIN_LOW_MIN_CYC,
	parameter SW_PULSE = `RSQ_SW_PULSE_CYC
) (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire reset_pin_n_in,
	input wire wr_en_in,
	input wire [15:0] wr_addr_in,
	input wire [7:0] wr_data_in,
	input wire [2:0] div_sel_in,
	input wire div_load_in,
	output reg core_rst_n_out,
	output reg sw_rst_active_out,
	output reg hw_rst_active_out,
	output reg ports_float_out,
	output reg ram_clear_ok_out,
	output reg usb_fs_init_out,
	output reg vector_fetch_out,
	output reg [2:0] cpu_div_sel_out,
	output reg cpu_clk_en_out,
	output reg sw_req_out
);

	// ----------------------------------------
	// Local constants
	// ----------------------------------------
	// Both counts are held in eight bits, so LOW_MIN and SW_PULSE must stay below 256.
	localparam [7:0] LOW_LAST = LOW_MIN[7:0] - 8'h01;
	localparam [7:0] SW_LOAD = SW_PULSE[7:0];

	// ----------------------------------------
	// Internal state
	// ----------------------------------------
	reg pin_s1_q;
	reg pin_s2_q;
	reg [7:0] low_cnt_q;
	reg [7:0] low_cnt_d;
	reg hw_hold_q;
	reg hw_hold_d;
	reg [7:0] sw_cnt_q;
	reg [7:0] sw_cnt_d;
	reg sw_req_d;
	reg in_rst_q;
	reg [4:0] div_cnt_q;
	reg [4:0] div_cnt_d;
	reg [2:0] div_sel_d;
	reg clk_en_d;
	wire sw_write;
	wire sw_busy;
	wire any_rst;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Highest divider count for a division code; unused codes fall back to the reset rate.
	function [4:0] div_mask;
		input [2:0] sel;
		case (sel)
			3'h0: div_mask = 5'h00;
			3'h1: div_mask = 5'h01;
			3'h2: div_mask = 5'h03;
			3'h3: div_mask = 5'h07;
			3'h4: div_mask = 5'h0f;
			default: div_mask = 5'h07;
		endcase
	endfunction

	// True for a byte write to mode register 0 with the software reset bit set.
	function is_swrst_write;
		input en;
		input [15:0] addr;
		input [7:0] data;
		is_swrst_write = en && (addr == `RSQ_PM0_ADDR) && data[`RSQ_PM0_SWRST_BIT];
	endfunction

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	// The pin idles high, so both flops reset high and no false low follows a reset.
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= reset_pin_n_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// ----------------------------------------
	// Low-time filter
	// ----------------------------------------
	// Short glitches are ignored: only a low held LOW_MIN cycles resets the core.
	always @* begin
		low_cnt_d = low_cnt_q;
		hw_hold_d = hw_hold_q;
		if (pin_s2_q) begin
			low_cnt_d = 8'h00;
			hw_hold_d = 1'b0;
		end else if (low_cnt_q < LOW_LAST) begin
			low_cnt_d = low_cnt_q + 8'h01;
		end else begin
			hw_hold_d = 1'b1;
		end
	end

	// A power-on reset is treated as a hardware reset, so storage may be cleared after it.
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			low_cnt_q <= 8'h00;
			hw_hold_q <= 1'b1;
		end else begin
			low_cnt_q <= low_cnt_d;
			hw_hold_q <= hw_hold_d;
		end
	end

	// ----------------------------------------
	// Software reset request
	// ----------------------------------------
	assign sw_write = is_swrst_write(wr_en_in, wr_addr_in, wr_data_in);
	assign sw_busy = (sw_cnt_q != 8'h00);
	assign any_rst = hw_hold_q || sw_busy;

	// A hardware reset overrides and cancels any pending software reset.
	// Writes that arrive while any reset is applied are dropped.
	always @* begin
		sw_cnt_d = sw_cnt_q;
		sw_req_d = sw_req_out;
		if (hw_hold_q) begin
			sw_cnt_d = 8'h00;
			sw_req_d = 1'b0;
		end else if (sw_write && !any_rst) begin
			sw_cnt_d = SW_LOAD;
			sw_req_d = 1'b1;
		end else if (sw_busy) begin
			sw_cnt_d = sw_cnt_q - 8'h01;
			if (sw_cnt_q == 8'h01) begin
				sw_req_d = 1'b0;
			end
		end
	end

	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			sw_cnt_q <= 8'h00;
			sw_req_out <= 1'b0;
		end else begin
			sw_cnt_q <= sw_cnt_d;
			sw_req_out <= sw_req_d;
		end
	end

	// ----------------------------------------
	// Reset outputs and storage qualifiers
	// ----------------------------------------
	// The software flag is masked by a hardware hold, so the two kinds never show at once.
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			in_rst_q <= 1'b1;
			core_rst_n_out <= 1'b0;
			sw_rst_active_out <= 1'b0;
			hw_rst_active_out <= 1'b1;
			ports_float_out <= 1'b1;
			ram_clear_ok_out <= 1'b1;
			usb_fs_init_out <= 1'b1;
			vector_fetch_out <= 1'b0;
		end else begin
			in_rst_q <= any_rst;
			core_rst_n_out <= !any_rst;
			hw_rst_active_out <= hw_hold_q;
			sw_rst_active_out <= sw_busy && !hw_hold_q;
			// Ports float while the pin is low, as seen after synchronising, and also while hw_hold_q is set.
			ports_float_out <= !pin_s2_q || hw_hold_q;
			ram_clear_ok_out <= hw_hold_q;
			usb_fs_init_out <= hw_hold_q;
			vector_fetch_out <= in_rst_q && !any_rst;
		end
	end

	// ----------------------------------------
	// CPU clock divider
	// ----------------------------------------
	// Loads are ignored during reset, so the first enables after any reset come at /8.
	always @* begin
		div_sel_d = cpu_div_sel_out;
		div_cnt_d = div_cnt_q;
		clk_en_d = 1'b0;
		if (any_rst) begin
			div_sel_d = `RSQ_DIV_RESET;
			div_cnt_d = 5'h00;
		end else begin
			if (div_load_in) begin
				div_sel_d = div_sel_in;
			end
			if (div_cnt_q >= div_mask(cpu_div_sel_out)) begin
				div_cnt_d = 5'h00;
				clk_en_d = 1'b1;
			end else begin
				div_cnt_d = div_cnt_q + 5'h01;
			end
		end
	end

	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cpu_div_sel_out <= `RSQ_DIV_RESET;
			div_cnt_q <= 5'h00;
			cpu_clk_en_out <= 1'b0;
		end else begin
			cpu_div_sel_out <= div_sel_d;
			div_cnt_q <= div_cnt_d;
			cpu_clk_en_out <= clk_en_d;
		end
	end

endmodule

// ===== verification/rsq_pin_model.sv
/* External reset circuit model that pulls the reset pin low on request.
   Assumes the bench calls hold from just after a clock edge. */
`timescale 1ns/1ps
module rsq_pin_model (
	input wire clk_in,
	output reg pin_n_out
);
initial pin_n_out = 1'b1;
task hold(input int n);
	@(posedge clk_in) #2 pin_n_out = 1'b0;
	repeat (n) @(posedge clk_in);
	#2 pin_n_out = 1'b1;
endtask
endmodule

// ===== verification/rsq_chk.sv
/* Checker on the reset sequencer outputs.
   Assumes it is bound to rsq_reset_sequencer. */
`timescale 1ns/1ps
module rsq_chk (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire core_rst_n_out,
	input wire sw_rst_active_out,
	input wire hw_rst_active_out,
	input wire ports_float_out,
	input wire ram_clear_ok_out,
	input wire usb_fs_init_out,
	input wire vector_fetch_out,
	input wire [2:0] cpu_div_sel_out,
	input wire sw_req_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (!rst_n_in);
property p_flt; hw_rst_active_out |-> ports_float_out; endproperty
a_flt: assert property (p_flt) else $error("ports driven");
property p_hw; hw_rst_active_out |-> !core_rst_n_out && ram_clear_ok_out && usb_fs_init_out; endproperty
a_hw: assert property (p_hw) else $error("hw reset");
property p_kp; sw_rst_active_out |-> !ram_clear_ok_out && !usb_fs_init_out; endproperty
a_kp: assert property (p_kp) else $error("storage lost");
property p_sws; $rose(sw_req_out) |=> !core_rst_n_out && sw_rst_active_out; endproperty
a_sws: assert property (p_sws) else $error("sw start");
property p_swe; $fell(sw_req_out) && !hw_rst_active_out |=> core_rst_n_out; endproperty
a_swe: assert property (p_swe) else $error("sw end");
property p_vec; $rose(core_rst_n_out) |-> vector_fetch_out ##1 !vector_fetch_out; endproperty
a_vec: assert property (p_vec) else $error("vector");
property p_div; !core_rst_n_out |-> cpu_div_sel_out == 3'h3; endproperty
a_div: assert property (p_div) else $error("divider");
endmodule
bind rsq_reset_sequencer rsq_chk u_chk (
	.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in),
	.core_rst_n_out(core_rst_n_out),
	.sw_rst_active_out(sw_rst_active_out),
	.hw_rst_active_out(hw_rst_active_out),
	.ports_float_out(ports_float_out),
	.ram_clear_ok_out(ram_clear_ok_out),
	.usb_fs_init_out(usb_fs_init_out),
	.vector_fetch_out(vector_fetch_out),
	.cpu_div_sel_out(cpu_div_sel_out),
	.sw_req_out(sw_req_out)
);

// ===== verification/tb_reset_sequencer.sv
/* Bench for the reset sequencer: pin reset, software reset, divider.
   Assumes the pin model and the checker are compiled with it. */
`timescale 1ns/1ps
module tb_reset_sequencer;
reg core_clk_in = 0, rst_n_in = 0, wr_en_in = 0, div_load_in = 0;
reg [15:0] wr_addr_in = 0;
reg [7:0] wr_data_in = 0;
reg [2:0] div_sel_in = 0;
wire reset_pin_n_in, core_rst_n_out, sw_rst_active_out, hw_rst_active_out, ports_float_out;
wire ram_clear_ok_out, usb_fs_init_out, vector_fetch_out, cpu_clk_en_out, sw_req_out;
wire [2:0] cpu_div_sel_out;
int failures = 0, samples_checked = 0;
always #12.5 core_clk_in = ~core_clk_in;
rsq_pin_model i_pin (.clk_in(core_clk_in), .pin_n_out(reset_pin_n_in));
rsq_reset_sequencer #(.SW_PULSE(2)) i_dut (
	.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in),
	.reset_pin_n_in(reset_pin_n_in),
	.wr_en_in(wr_en_in),
	.wr_addr_in(wr_addr_in),
	.wr_data_in(wr_data_in),
	.div_sel_in(div_sel_in),
	.div_load_in(div_load_in),
	.core_rst_n_out(core_rst_n_out),
	.sw_rst_active_out(sw_rst_active_out),
	.hw_rst_active_out(hw_rst_active_out),
	.ports_float_out(ports_float_out),
	.ram_clear_ok_out(ram_clear_ok_out),
	.usb_fs_init_out(usb_fs_init_out),
	.vector_fetch_out(vector_fetch_out),
	.cpu_div_sel_out(cpu_div_sel_out),
	.cpu_clk_en_out(cpu_clk_en_out),
	.sw_req_out(sw_req_out)
);
task results;
	$display("checked %0d failed %0d", samples_checked, failures);
	if (failures == 0 && samples_checked > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
task chk(input [3:0] s, e);
	samples_checked++;
	if (s !== e)
		$display("unexpected at %0t: %h not %h", $time, s, e);
	failures += (s !== e);
endtask
task cyc(input int n);
	repeat (n) @(posedge core_clk_in);
	#2;
endtask
task wr(input [15:0] ad, input [7:0] dt);
	{wr_addr_in, wr_data_in, wr_en_in} = {ad, dt, 1'b1};
	cyc(1);
	wr_en_in = 0;
endtask
task wt;
	for (int i = 0; i < 40 && core_rst_n_out !== 1; i++)
		cyc(1);
endtask
task t_hw;
	i_pin.hold(10);
	cyc(4);
	chk(core_rst_n_out, 4'h1);
	i_pin.hold(25);
	chk({core_rst_n_out, ports_float_out, ram_clear_ok_out, usb_fs_init_out}, 4'h7);
	wt;
	chk({vector_fetch_out, cpu_div_sel_out}, 4'hb);
endtask
task t_sw;
	{div_sel_in, div_load_in} = 4'h1;
	cyc(1);
	div_load_in = 0;
	wr(16'h0005, 8'h08);
	cyc(1);
	wr(16'h0004, 8'hf7);
	cyc(2);
	chk({core_rst_n_out, cpu_div_sel_out}, 4'h8);
	wr(16'h0004, 8'h08);
	cyc(2);
	chk({core_rst_n_out, sw_rst_active_out, ram_clear_ok_out, usb_fs_init_out}, 4'h4);
	wt;
	chk({sw_req_out, cpu_div_sel_out}, 4'h3);
endtask
task t_div;
	reg [3:0] n;
	n = 4'h0;
	repeat (16) begin
		cyc(1);
		n = n + cpu_clk_en_out;
	end
	chk(n, 4'h2);
	{div_sel_in, div_load_in} = {3'h1, 1'b1};
	cyc(1);
	div_load_in = 0;
	cyc(2);
	n = 4'h0;
	repeat (16) begin
		cyc(1);
		n = n + cpu_clk_en_out;
	end
	chk(n, 4'h8);
endtask
initial begin
	cyc(3);
	rst_n_in = 1;
	cyc(3);
	t_hw;
	t_sw;
	t_div;
	results;
end
initial begin
	#10us;
	failures++;
	results;
end
endmodule
